// ==== inc/cic_pkg.sv ====
// cic_pkg: constants and types for the core interrupt controller
// assumes an 8-bit register port and a core sequencer that consumes vector requests
package cic_pkg;
  localparam logic [7:0]  IRQ_STATUS_CONTROL_ADDR = 8'h07;
  localparam logic [7:0]  PERIPH_REQUEST_ADDR     = 8'h16;
  localparam logic [7:0]  PERIPH_ENABLE_ADDR      = 8'h17;
  localparam logic [7:0]  CORE_STATUS_ADDR        = 8'h06;
  localparam int          GLOBAL_DISABLE_BIT      = 4;
  localparam int          SUMMARY_BIT             = 7;
  localparam int          CLKPIN_FLAG_BIT         = 6;
  localparam int          TIMER_ZERO_FLAG_BIT           = 5;
  localparam int          EXT_FLAG_BIT            = 4;
  localparam int          GROUP_ENABLE_BIT        = 3;
  localparam logic [7:0]  STATUS_CONTROL_RESET    = 8'h00;
  localparam logic [7:0]  PERIPH_REQUEST_RESET    = 8'h02;
  localparam logic [7:0]  PERIPH_ENABLE_RESET     = 8'h00;
  localparam logic [15:0] VEC_RESET               = 16'h0000;
  localparam logic [15:0] VEC_EXT_PIN             = 16'h0008;
  localparam logic [15:0] VEC_TIMER_ZERO                = 16'h0010;
  localparam logic [15:0] VEC_CLK_PIN             = 16'h0018;
  localparam logic [15:0] VEC_PERIPH              = 16'h0020;
  localparam int          NUM_PERIPH              = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cic_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } cic_vector_t;
endpackage : cic_pkg

// ==== rtl/cic_edge_sync.sv ====
// cic_edge_sync: two-flop synchroniser and selectable edge detector for one pin
// assumes the pin is asynchronous to core_clk
module cic_edge_sync (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic pin,
  input  wire logic rising_sel,
  output logic      edge_pulse
);
  logic       meta_r;
  logic       sync_r;
  logic       prev_r;
  logic [2:0] fill_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      fill_r <= 3'h0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // edges masked until prev_r holds a real pin sample: a pin idling high gives no false edge
  assign edge_pulse = fill_r[2] & (rising_sel ? (sync_r & ~prev_r) : (~sync_r & prev_r));
endmodule : cic_edge_sync

// ==== rtl/cic_core.sv ====
// cic_core: interrupt controller of an 8-bit core, flags, masks and vector selection
// assumes the sequencer takes vector_valid as a one-cycle load and drives irq_return on return
// Function
// - eleven sources: ext pin, port change, four timers, tx, rx, two captures, clock pin
// - global disable set blocks every vector response regardless of enables; wake-up still occurs
// - on accept: set global disable, push return address, load vector
// - four vectors: ext pin, timer zero, clock pin, shared peripheral
// - dedicated vectors clear their flag; peripheral vector leaves flags alone
// - flags set on their condition regardless of enables or global disable
// - external events answered with latency, one more cycle after two-cycle instructions
// - return instruction pops stack and clears global disable together
// - summary bit 7 read-only OR of peripheral flag AND enable
// - flag set while its enable is cleared, globally enabled: branch to reset address; peripheral flags only when bit 3 is cleared, not on 17h writes
// - bit 6 set on clock pin edge, cleared on vector 18h
// - bit 5 set on timer zero overflow, cleared on vector 10h
// - bit 4 set on external pin edge, cleared on vector 08h
// - bit 3 gates all peripheral requests as a group
// - bits 2,1,0 enable clock pin, timer zero, external pin
// - wake-up sets flags; vectors if global disable clear
// - global disable is core status bit 4, set by every reset
//
// The address-and-strobe port was decided locally.
module cic_core
  import cic_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire cic_pkg::cic_reg_req_t reg_req,
  output logic [7:0]                 rdata_r,
  input  wire logic                  external_irq_pin,
  input  wire logic                  timer_clock_pin,
  input  wire logic                  ext_rising_sel,
  input  wire logic                  clk_rising_sel,
  input  wire logic                  timer_zero_overflow,
  input  wire logic [7:0]            periph_events,
  input  wire logic                  instr_boundary,
  input  wire logic                  two_cycle_instr,
  input  wire logic                  irq_return,
  input  wire logic                  sleeping,
  output cic_pkg::cic_vector_t       vector_r,
  output logic                       stack_push_r,
  output logic                       stack_pop_r,
  output logic                       wake_r,
  output logic                       global_irq_disable_r
);
  import cic_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_TAKE = 3'b100
  } cic_state_t;

  cic_state_t state_r;
  logic [6:0] ctrl_r;
  logic [7:0] peripheral_request_flags;
  logic [7:0] peripheral_enable_bits;
  logic       ext_edge;
  logic       clk_edge;
  logic       peripheral_summary_flag;
  logic       any_req;
  logic       en_drop_hit;
  logic       take_haz;
  logic       take_req;
  logic [15:0] sel_vec;
  logic       wr_ctrl;
  logic       wr_status;
  logic [7:0] core_status_register;

  cic_edge_sync u_ext_sync (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .pin        (external_irq_pin),
    .rising_sel (ext_rising_sel),
    .edge_pulse (ext_edge)
  );

  cic_edge_sync u_clk_sync (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .pin        (timer_clock_pin),
    .rising_sel (clk_rising_sel),
    .edge_pulse (clk_edge)
  );

  assign wr_ctrl   = reg_req.wr && (reg_req.addr == IRQ_STATUS_CONTROL_ADDR);
  assign wr_status = reg_req.wr && (reg_req.addr == CORE_STATUS_ADDR);

  // summary bit, never stored
  assign peripheral_summary_flag = |(peripheral_request_flags & peripheral_enable_bits);

  // ctrl_r bits: 6 clk flag, 5 timer_zero flag, 4 ext flag, 3 group en, 2..0 enables
  assign any_req = !global_irq_disable_r && (
    (ctrl_r[CLKPIN_FLAG_BIT] & ctrl_r[2]) | (ctrl_r[TIMER_ZERO_FLAG_BIT] & ctrl_r[1]) |
    (ctrl_r[EXT_FLAG_BIT] & ctrl_r[0]) |
    (peripheral_summary_flag & ctrl_r[GROUP_ENABLE_BIT]));

  // enable dropped in the cycle its flag sets, interrupts enabled
  assign en_drop_hit = wr_ctrl && !global_irq_disable_r && (
    (ext_edge & ctrl_r[0] & ~reg_req.wdata[0]) |
    (timer_zero_overflow & ctrl_r[1] & ~reg_req.wdata[1]) |
    (clk_edge & ctrl_r[2] & ~reg_req.wdata[2]) |
    (|(periph_events & peripheral_enable_bits) & ctrl_r[GROUP_ENABLE_BIT]
     & ~reg_req.wdata[GROUP_ENABLE_BIT]));

  // hazard branch wins; a normal take waits for a one-cycle instruction boundary
  assign take_haz = en_drop_hit;
  assign take_req = (state_r == ST_HOLD) && any_req
                    && instr_boundary && !two_cycle_instr;

  // fixed priority among the dedicated vectors
  always_comb begin
    if (ctrl_r[EXT_FLAG_BIT] && ctrl_r[0]) begin
      sel_vec = VEC_EXT_PIN;
    end else if (ctrl_r[TIMER_ZERO_FLAG_BIT] && ctrl_r[1]) begin
      sel_vec = VEC_TIMER_ZERO;
    end else if (ctrl_r[CLKPIN_FLAG_BIT] && ctrl_r[2]) begin
      sel_vec = VEC_CLK_PIN;
    end else begin
      sel_vec = VEC_PERIPH;
    end
  end

  // acceptance sequencer, waits for instruction boundary
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take_haz) begin
            state_r <= ST_TAKE;
          end else if (any_req) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (take_haz || take_req) begin
            state_r <= ST_TAKE;
          end else if (!any_req) begin
            state_r <= ST_IDLE;
          end
        end
        ST_TAKE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vector_r     <= '0;
      stack_push_r <= 1'b0;
    end else if (take_haz) begin
      vector_r     <= '{valid: 1'b1, addr: VEC_RESET};
      stack_push_r <= 1'b1;
    end else if (take_req) begin
      vector_r     <= '{valid: 1'b1, addr: sel_vec};
      stack_push_r <= 1'b1;
    end else begin
      vector_r     <= '0;
      stack_push_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stack_pop_r <= 1'b0;
    end else begin
      stack_pop_r <= irq_return;
    end
  end

  // global disable: reset sets, accept sets, return clears
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      global_irq_disable_r <= 1'b1;
    end else if (take_haz || take_req) begin
      global_irq_disable_r <= 1'b1;
    end else if (irq_return) begin
      global_irq_disable_r <= 1'b0;
    end else if (wr_status) begin
      global_irq_disable_r <= reg_req.wdata[GLOBAL_DISABLE_BIT];
    end
  end

  // dedicated flags and enables; set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= STATUS_CONTROL_RESET[6:0];
    end else begin
      logic [6:0] n;
      n = ctrl_r;
      if (wr_ctrl) begin
        n = reg_req.wdata[6:0];
      end
      if (vector_r.valid && vector_r.addr == VEC_EXT_PIN) begin
        n[EXT_FLAG_BIT] = 1'b0;
      end
      if (vector_r.valid && vector_r.addr == VEC_TIMER_ZERO) begin
        n[TIMER_ZERO_FLAG_BIT] = 1'b0;
      end
      if (vector_r.valid && vector_r.addr == VEC_CLK_PIN) begin
        n[CLKPIN_FLAG_BIT] = 1'b0;
      end
      if (ext_edge) begin
        n[EXT_FLAG_BIT] = 1'b1;
      end
      if (timer_zero_overflow) begin
        n[TIMER_ZERO_FLAG_BIT] = 1'b1;
      end
      if (clk_edge) begin
        n[CLKPIN_FLAG_BIT] = 1'b1;
      end
      ctrl_r <= n;
    end
  end

  // peripheral flags: bit 7 port change, 6..4 timers, 3..2 captures, 1 tx, 0 rx
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : g_pf
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          peripheral_request_flags[g] <= PERIPH_REQUEST_RESET[g];
        end else if (periph_events[g]) begin
          peripheral_request_flags[g] <= 1'b1;
        end else if (reg_req.wr && reg_req.addr == PERIPH_REQUEST_ADDR) begin
          peripheral_request_flags[g] <= reg_req.wdata[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      peripheral_enable_bits <= PERIPH_ENABLE_RESET;
    end else if (reg_req.wr && reg_req.addr == PERIPH_ENABLE_ADDR) begin
      peripheral_enable_bits <= reg_req.wdata;
    end
  end

  // wake on any enabled flag; vectoring then proceeds via any_req
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= sleeping && ((ctrl_r[6] & ctrl_r[2]) | (ctrl_r[5] & ctrl_r[1]) |
                (ctrl_r[4] & ctrl_r[0]) | (peripheral_summary_flag & ctrl_r[3]));
    end
  end

  assign core_status_register = {3'b000, global_irq_disable_r, 4'h0};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        IRQ_STATUS_CONTROL_ADDR: rdata_r <= {peripheral_summary_flag, ctrl_r};
        PERIPH_REQUEST_ADDR:     rdata_r <= peripheral_request_flags;
        PERIPH_ENABLE_ADDR:      rdata_r <= peripheral_enable_bits;
        CORE_STATUS_ADDR:        rdata_r <= core_status_register;
        default:                 rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  gd_blocks_a: assert property (global_irq_disable_r && state_r == ST_IDLE
    && !en_drop_hit |=> state_r != ST_HOLD) else $error("response while disabled");
  accept_sets_gd_a: assert property (vector_r.valid
    |-> global_irq_disable_r && stack_push_r) else $error("vector without disable or push");
  ret_clears_a: assert property (irq_return && state_r == ST_IDLE && !en_drop_hit
    |=> !global_irq_disable_r && stack_pop_r) else $error("return failed");
  summary_or_a: assert property (reg_req.rd && reg_req.addr == IRQ_STATUS_CONTROL_ADDR
    |=> rdata_r[SUMMARY_BIT] == $past(|(peripheral_request_flags & peripheral_enable_bits)))
    else $error("summary mismatch");
  ext_clear_a: assert property (vector_r.valid && vector_r.addr == VEC_EXT_PIN
    && !ext_edge && !wr_ctrl |=> !ctrl_r[EXT_FLAG_BIT]) else $error("ext flag kept");
  tmr_set_a: assert property (timer_zero_overflow |=> ctrl_r[TIMER_ZERO_FLAG_BIT])
    else $error("timer flag lost");
  clk_set_a: assert property (clk_edge |=> ctrl_r[CLKPIN_FLAG_BIT])
    else $error("clock pin flag lost");
  drop_reset_a: assert property (en_drop_hit && state_r == ST_IDLE
    |=> vector_r.valid && vector_r.addr == VEC_RESET) else $error("no reset branch");
endmodule : cic_core

// ==== tb/cic_seq_model.sv ====
// cic_seq_model: stand-in for the core sequencer beside the controller
// assumes stack strobes from the controller are one-cycle pulses
module cic_seq_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       slow,
  input  wire logic       stack_push_r,
  input  wire logic       stack_pop_r,
  output logic            instr_boundary,
  output logic            two_cycle_instr,
  output logic [4:0]      depth_r
);
  logic phase_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) phase_r <= 1'b0;
    else phase_r <= slow & ~phase_r;
  end
  // slow mode: every other instruction takes two cycles
  assign instr_boundary  = 1'b1;
  assign two_cycle_instr = slow & ~phase_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) depth_r <= 5'h00;
    else depth_r <= depth_r + 5'(stack_push_r) - 5'(stack_pop_r);
  end
endmodule : cic_seq_model

// ==== tb/tb_core_interrupt_controller.sv ====
// tb_core_interrupt_controller: directed scenarios for cic_core
// assumes cic_seq_model stands in for the core sequencer
module tb_core_interrupt_controller;
  timeunit 1ns;
  timeprecision 100ps;
  import cic_pkg::*;
  logic         core_clk, nrst, ext_pin, clk_pin, timer_zero_ov, irq_return, sleeping, slow;
  logic         push, pop, wake, gid, bnd, tc, ext_sel, clk_sel;
  logic [7:0]   rdata_r;
  logic [7:0]   pev;
  logic [4:0]   depth;
  cic_reg_req_t req;
  cic_vector_t  vector_r;
  int           checks, bad_count;
  localparam logic [7:0] ISC = IRQ_STATUS_CONTROL_ADDR;

  cic_core i_dut (.core_clk(core_clk), .nrst(nrst), .reg_req(req), .rdata_r(rdata_r),
    .external_irq_pin(ext_pin), .timer_clock_pin(clk_pin), .ext_rising_sel(ext_sel),
    .clk_rising_sel(clk_sel), .timer_zero_overflow(timer_zero_ov), .periph_events(pev),
    .instr_boundary(bnd), .two_cycle_instr(tc), .irq_return(irq_return),
    .sleeping(sleeping), .vector_r(vector_r), .stack_push_r(push), .stack_pop_r(pop),
    .wake_r(wake), .global_irq_disable_r(gid));
  cic_seq_model i_seq (.core_clk(core_clk), .nrst(nrst), .slow(slow), .stack_push_r(push),
    .stack_pop_r(pop), .instr_boundary(bnd), .two_cycle_instr(tc), .depth_r(depth));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // one clock, dropping the timer, peripheral-event and write pulses
  task automatic tick;
    @(posedge core_clk);
    timer_zero_ov <= 1'b0;
    pev <= 8'h00;
    req.wr <= 1'b0;
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp);
    @(posedge core_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk({8'h00, rdata_r & msk}, {8'h00, exp}, "read data");
  endtask : rd

  task automatic no_vec(input int n);
    repeat (n) begin
      tick();
      chk(16'(vector_r.valid), 16'h0000, "unexpected vector");
    end
  endtask : no_vec

  task automatic wait_vec(input logic [15:0] v);
    int   i;
    logic p;
    p = 1'b0;
    #1;
    for (i = 0; i < 12 && vector_r.valid !== 1'b1; i++) begin
      p = tc;
      tick();
    end
    if (i == 12) begin
      bad_count++;
      $display("[FAIL] %0t vector timeout", $time);
      conclude();
    end else begin
      chk(vector_r.addr, v, "vector address");
      chk(16'(p), 16'h0000, "vector after two-cycle step");
    end
  endtask : wait_vec

  task automatic ret;
    @(posedge core_clk);
    irq_return <= 1'b1;
    @(posedge core_clk);
    irq_return <= 1'b0;
    #1 chk(16'(pop), 16'h0001, "pop");
    chk(16'(gid), 16'h0000, "disable after return");
  endtask : ret

  task automatic t_reset;
    chk(16'(gid), 16'h0001, "disable at reset");
    rd(ISC, 8'hff, STATUS_CONTROL_RESET);
    rd(PERIPH_REQUEST_ADDR, 8'hff, PERIPH_REQUEST_RESET);
    rd(PERIPH_ENABLE_ADDR, 8'hff, PERIPH_ENABLE_RESET);
    rd(8'h30, 8'hff, 8'h00);
  endtask : t_reset

  task automatic t_masked;
    wr(ISC, 8'h07);
    @(posedge core_clk);
    timer_zero_ov <= 1'b1;
    no_vec(8);
    rd(ISC, 8'h20, 8'h20);
    wr(ISC, 8'h00);
  endtask : t_masked

  task automatic t_dedicated;
    logic [15:0] vec [3] = '{VEC_EXT_PIN, VEC_TIMER_ZERO, VEC_CLK_PIN};
    for (int i = 0; i < 3; i++) begin
      wr(ISC, 8'h01 << i);
      wr(CORE_STATUS_ADDR, 8'h00);
      @(posedge core_clk);
      ext_pin <= (i == 0);
      timer_zero_ov <= (i == 1);
      clk_pin <= (i == 2);
      wait_vec(vec[i]);
      chk(16'(push), 16'h0001, "push");
      chk(16'(gid), 16'h0001, "disable on accept");
      rd(ISC, 8'h10 << i, 8'h00);
      chk(16'(depth), 16'h0001, "stack depth");
      ret();
    end
  endtask : t_dedicated

  task automatic t_periph;
    wr(PERIPH_ENABLE_ADDR, 8'h80);
    @(posedge core_clk);
    slow <= 1'b1;
    pev <= 8'h80;
    no_vec(6);
    rd(ISC, 8'h80, 8'h80);
    wr(PERIPH_ENABLE_ADDR, 8'h00);
    rd(ISC, 8'h80, 8'h00);
    rd(PERIPH_REQUEST_ADDR, 8'h80, 8'h80);
    wr(PERIPH_ENABLE_ADDR, 8'h80);
    wr(ISC, 8'h08);
    wait_vec(VEC_PERIPH);
    rd(PERIPH_REQUEST_ADDR, 8'h80, 8'h80);
    wr(PERIPH_REQUEST_ADDR, 8'h00);
    rd(PERIPH_REQUEST_ADDR, 8'h80, 8'h00);
    ret();
    wr(CORE_STATUS_ADDR, 8'h10);
    wr(ISC, 8'h00);
  endtask : t_periph

  task automatic t_hazard;
    wr(ISC, 8'h02);
    wr(CORE_STATUS_ADDR, 8'h00);
    @(posedge core_clk);
    slow <= 1'b0;
    req <= '{ISC, 8'h00, 1'b1, 1'b0};
    timer_zero_ov <= 1'b1;
    wait_vec(VEC_RESET);
    wr(ISC, 8'h00);
  endtask : t_hazard

  task automatic t_sleep;
    int i;
    wr(CORE_STATUS_ADDR, 8'h10);
    wr(ISC, 8'h01);
    @(posedge core_clk);
    sleeping <= 1'b1;
    ext_pin <= 1'b1;
    for (i = 0; i < 10 && wake !== 1'b1; i++) tick();
    chk(16'(wake), 16'h0001, "wake");
    rd(ISC, 8'h10, 8'h10);
    wr(CORE_STATUS_ADDR, 8'h00);
    wait_vec(VEC_EXT_PIN);
  endtask : t_sleep

  // second reset with both pins high, then falling-edge selection
  task automatic t_rereset;
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk(16'(gid), 16'h0001, "disable after second reset");
    no_vec(3);
    rd(ISC, 8'hff, STATUS_CONTROL_RESET);
    @(posedge core_clk);
    ext_sel <= 1'b0;
    clk_sel <= 1'b0;
    ext_pin <= 1'b0;
    clk_pin <= 1'b0;
    no_vec(4);
    rd(ISC, 8'hff, 8'h50);
  endtask : t_rereset

  initial begin
    {nrst, ext_pin, clk_pin, timer_zero_ov, irq_return, sleeping, slow} = '0;
    req = '0;
    pev = 8'h00;
    ext_sel = 1'b1;
    clk_sel = 1'b1;
    checks = 0;
    bad_count = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_masked();
    t_dedicated();
    t_periph();
    t_hazard();
    t_sleep();
    t_rereset();
    conclude();
  end
endmodule : tb_core_interrupt_controller
